// ### design/brk_unit.sv
// Address breakpoint unit with Avalon-MM register slave
// Function
// RULE_01: Enabled full address match raises break
// RULE_02: Enable bit 7, read/write, reset clear
// RULE_03: Active bit set on address match
// RULE_04: Writing one to active forces break
// RULE_05: Software clears active before leaving routine
// RULE_06: Breakpoint high/low bytes, reset to zero
// RULE_07: Wait flag set when break ends wait
// RULE_08: Wait status used only in emulation
// RULE_09: In break, clears need clear enable
// RULE_10: Software may rewind stacked return address
// RULE_11: Request makes core inject software interrupt
// RULE_12: Opcode hit defers, operand hit executes
// RULE_13: Forced break taken before next instruction
// RULE_14: Writing zero clears the wait flag
// RULE_15: Break state held from entry to return
//
// Register access over Avalon-MM and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module brk_unit
  import brk_pkg::*;
#(
  parameter int unsigned AW = ADDR_W
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [15:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [DATA_W-1:0] writedata,
  output logic [DATA_W-1:0] readdata,
  output logic waitrequest,
  input wire cpu_cycle_t cpu,
  input wire core_status_t core,
  output logic break_request,
  output logic break_defer_opcode,
  output logic break_state,
  output logic flag_clear_allowed,
  output logic irq
);
  initial begin
    if (AW != ADDR_W) begin
      $error("brk_unit: AW must equal 16");
    end
  end

  logic enable;
  logic active;
  logic [REG_W-1:0] bp_high;
  logic [REG_W-1:0] bp_low;
  logic wait_flag;
  logic clear_enable;
  logic [EV_N-1:0] ev_mask;
  logic [EV_N-1:0] ev_status;
  logic hit;
  logic wr;
  logic rd;
  logic soft_break;
  logic entry;
  logic wait_exit;
  logic next_break_state;
  logic [REG_W-1:0] rd_byte;

  // Bus strobes act only at the edge where waitrequest is low
  assign wr = write && !waitrequest;
  assign rd = read && !waitrequest;
  // RULE_04: write of one forces break
  assign soft_break = wr && (address == REG_STATUS_CONTROL) && writedata[ACTIVE_BIT];
  // RULE_11: core takes the request here
  assign entry = core.swi_taken && break_request;
  // RULE_07: break ended wait mode
  // RULE_08: only under emulation
  assign wait_exit = entry && core.wait_mode && core.emulation;

  brk_addr_match #(
    .WIDTH(AW)
  ) u_match (
    .cpu_addr(cpu.addr),
    .cpu_valid(cpu.valid),
    .bp_addr({bp_high, bp_low}),
    .enable(enable),
    .hit(hit)
  );

  brk_event_flags #(
    .N(EV_N)
  ) u_events (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .event_set({wait_exit, soft_break, hit}),
    .read_clear(rd && (address == REG_EVENT_STATUS)),
    .mask(ev_mask),
    .status(ev_status),
    .irq(irq)
  );

  // One wait state per access; idle high so nothing slips through
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      waitrequest <= 1'b1;
    end else if (waitrequest && (read || write)) begin
      waitrequest <= 1'b0;
    end else begin
      waitrequest <= 1'b1;
    end
  end

  always_comb begin
    rd_byte = BYTE_RESET;
    unique case (address)
      REG_STATUS_CONTROL: begin
        rd_byte[ENABLE_BIT] = enable;
        rd_byte[ACTIVE_BIT] = active;
      end
      REG_BP_HIGH: rd_byte = bp_high;
      REG_BP_LOW: rd_byte = bp_low;
      REG_WAIT_STATUS: rd_byte[WAIT_FLAG_BIT] = wait_flag;
      REG_FLAG_CLEAR: rd_byte[CLEAR_ENABLE_BIT] = clear_enable;
      // Events landing on the capture edge are reported before the clearing read
      REG_EVENT_STATUS: rd_byte[EV_N-1:0] = ev_status | {wait_exit, soft_break, hit};
      REG_EVENT_MASK: rd_byte[EV_N-1:0] = ev_mask;
      default: rd_byte = BYTE_RESET;
    endcase
  end

  // Read data prepared while waitrequest still high
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      readdata <= DATA_RESET;
    end else if (read && waitrequest) begin
      readdata <= {24'h00_0000, rd_byte};
    end
  end

  // RULE_02: enable bit storage
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      enable <= 1'b0;
    end else if (wr && (address == REG_STATUS_CONTROL)) begin
      enable <= writedata[ENABLE_BIT];
    end
  end

  // RULE_03: match sets active bit
  // RULE_05: software write clears it
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      active <= 1'b0;
    end else if (hit) begin
      active <= 1'b1;
    end else if (wr && (address == REG_STATUS_CONTROL)) begin
      active <= writedata[ACTIVE_BIT];
    end
  end

  // RULE_06: breakpoint address bytes
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      bp_high <= BYTE_RESET;
      bp_low <= BYTE_RESET;
    end else begin
      if (wr && (address == REG_BP_HIGH)) begin
        bp_high <= writedata[REG_W-1:0];
      end
      if (wr && (address == REG_BP_LOW)) begin
        bp_low <= writedata[REG_W-1:0];
      end
    end
  end

  // RULE_07: set on wait exit, set wins
  // RULE_14: write of zero clears
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wait_flag <= 1'b0;
    end else if (wait_exit) begin
      wait_flag <= 1'b1;
    end else if (wr && (address == REG_WAIT_STATUS) && !writedata[WAIT_FLAG_BIT]) begin
      wait_flag <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      clear_enable <= 1'b0;
      ev_mask <= EVENT_RESET;
    end else begin
      if (wr && (address == REG_FLAG_CLEAR)) begin
        clear_enable <= writedata[CLEAR_ENABLE_BIT];
      end
      if (wr && (address == REG_EVENT_MASK)) begin
        ev_mask <= writedata[EV_N-1:0];
      end
    end
  end

  // RULE_01: request on enabled match
  // RULE_13: forced request, no deferral
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      break_request <= 1'b0;
    end else if (hit || soft_break) begin
      break_request <= 1'b1;
    end else if (core.swi_taken) begin
      break_request <= 1'b0;
    end
  end

  // RULE_12: opcode hit defers instruction
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      break_defer_opcode <= 1'b0;
    end else if (hit) begin
      break_defer_opcode <= cpu.opcode;
    end else if (soft_break || core.swi_taken) begin
      break_defer_opcode <= 1'b0;
    end
  end

  // RULE_15: entry to return
  always_comb begin
    next_break_state = break_state;
    if (entry) begin
      next_break_state = 1'b1;
    end else if (core.rti_done) begin
      next_break_state = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      break_state <= 1'b0;
    end else begin
      break_state <= next_break_state;
    end
  end

  // RULE_09: clears gated in break state
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      flag_clear_allowed <= 1'b1;
    end else begin
      flag_clear_allowed <= !next_break_state || clear_enable;
    end
  end

  a_match_request: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_01
    hit |=> break_request)
    else $error("address hit did not raise request");

  a_no_match_off: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_01
    (!enable && !soft_break && !break_request && !core.swi_taken) |=> !break_request)
    else $error("request without enable or force");

  a_enable_write: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_02
    (wr && address == REG_STATUS_CONTROL) |=> (enable == $past(writedata[ENABLE_BIT])))
    else $error("enable bit did not take written value");

  a_active_set: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_03
    hit |=> active)
    else $error("active bit not set on match");

  a_soft_break: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_04
    soft_break |=> (break_request && !break_defer_opcode && ev_status[EV_SOFT]))
    else $error("forced break not requested");

  a_bp_write: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_06
    (wr && address == REG_BP_LOW) |=> (bp_low == $past(writedata[7:0])))
    else $error("breakpoint low byte not stored");

  a_wait_flag: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_07
    (entry && core.wait_mode && core.emulation) |=> wait_flag)
    else $error("wait flag not set on wait exit");

  a_wait_emul: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_08
    (!core.emulation && !wait_flag) |=> !wait_flag)
    else $error("wait flag set outside emulation");

  a_wait_clear: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_14
    (wr && address == REG_WAIT_STATUS && !writedata[WAIT_FLAG_BIT] && !wait_exit)
      |=> !wait_flag)
    else $error("wait flag not cleared by zero write");

  a_clear_gate: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_09
    (break_state && !clear_enable && !core.rti_done) |=> !flag_clear_allowed)
    else $error("clears allowed in break without enable");

  a_state_hold: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_15
    (break_state && !core.rti_done) |=> break_state)
    else $error("break state dropped before return");

  a_state_entry: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_15
    entry |=> (break_state && (!break_request || $past(hit || soft_break))))
    else $error("break state not entered");

  a_opcode_defer: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_12
    (hit && cpu.opcode) |=> break_defer_opcode)
    else $error("opcode hit not deferred");

  a_bus_answer: assert property (@(posedge core_clk) disable iff (!rst_n)
    ((read || write) && waitrequest) |=> !waitrequest)
    else $error("bus request not answered in one cycle");

  a_request_drop: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_11
    (core.swi_taken && !hit && !soft_break) |=> !break_request)
    else $error("request held after core took it");

  a_state_leave: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_15
    (core.rti_done && !entry) |=> !break_state)
    else $error("break state kept after return");

  a_clear_open: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_09
    (!break_state && !entry) |=> flag_clear_allowed)
    else $error("clears blocked outside break state");

  a_active_clear: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_05
    (wr && address == REG_STATUS_CONTROL && !writedata[ACTIVE_BIT] && !hit) |=> !active)
    else $error("active bit not cleared by zero write");

  a_bp_high: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_06
    (wr && address == REG_BP_HIGH) |=> (bp_high == $past(writedata[7:0])))
    else $error("breakpoint high byte not stored");

  a_wait_stand: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_07
    (wait_flag && !(wr && address == REG_WAIT_STATUS)) |=> wait_flag)
    else $error("wait flag lost without clearing write");

  a_bus_release: assert property (@(posedge core_clk) disable iff (!rst_n)
    !waitrequest |=> waitrequest)
    else $error("wait state missing after answer");
endmodule : brk_unit

// ### design/brk_pkg.sv
// Shared constants and carrier types of the address breakpoint unit
package brk_pkg;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned REG_W = 8;
  // Register addresses; compared directly with the bus address, no scaling
  localparam logic [15:0] REG_WAIT_STATUS = 16'hfe00;
  localparam logic [15:0] REG_FLAG_CLEAR = 16'hfe03;
  localparam logic [15:0] REG_BP_HIGH = 16'hfe0c;
  localparam logic [15:0] REG_BP_LOW = 16'hfe0d;
  localparam logic [15:0] REG_STATUS_CONTROL = 16'hfe0e;
  localparam logic [15:0] REG_EVENT_STATUS = 16'hfe10;
  localparam logic [15:0] REG_EVENT_MASK = 16'hfe11;
  // Field positions
  localparam int unsigned ENABLE_BIT = 7;
  localparam int unsigned ACTIVE_BIT = 6;
  localparam int unsigned WAIT_FLAG_BIT = 1;
  localparam int unsigned CLEAR_ENABLE_BIT = 7;
  // Event bits of the sticky status register
  localparam int unsigned EV_MATCH = 0;
  localparam int unsigned EV_SOFT = 1;
  localparam int unsigned EV_WAIT = 2;
  localparam int unsigned EV_N = 3;
  // Reset values
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [EV_N-1:0] EVENT_RESET = 3'h0;
  localparam logic [DATA_W-1:0] DATA_RESET = 32'h0000_0000;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic valid;
    logic opcode;
  } cpu_cycle_t;

  typedef struct packed {
    logic swi_taken;
    logic rti_done;
    logic wait_mode;
    logic emulation;
  } core_status_t;
endpackage : brk_pkg

// ### design/brk_addr_match.sv
// Full-width comparator of the CPU address against the breakpoint
`timescale 1ns/1ps
module brk_addr_match
  import brk_pkg::*;
#(
  parameter int unsigned WIDTH = ADDR_W
) (
  input wire logic [WIDTH-1:0] cpu_addr,
  input wire logic cpu_valid,
  input wire logic [WIDTH-1:0] bp_addr,
  input wire logic enable,
  output logic hit
);
  initial begin
    if (WIDTH != 16) begin
      $error("brk_addr_match: WIDTH must be 16");
    end
  end

  // RULE_01: gated compare
  assign hit = enable && cpu_valid && (cpu_addr == bp_addr);
endmodule : brk_addr_match

// ### design/brk_event_flags.sv
// Sticky event flags with mask and one level interrupt
`timescale 1ns/1ps
module brk_event_flags
  import brk_pkg::*;
#(
  parameter int unsigned N = EV_N
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [N-1:0] event_set,
  input wire logic read_clear,
  input wire logic [N-1:0] mask,
  output logic [N-1:0] status,
  output logic irq
);
  initial begin
    if (N < 1 || N > 8) begin
      $error("brk_event_flags: N must be 1..8");
    end
  end

  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_flag
      // Set wins over a clearing read in the same cycle
      always_ff @(posedge core_clk) begin
        if (!rst_n) begin
          status[i] <= 1'b0;
        end else if (event_set[i]) begin
          status[i] <= 1'b1;
        end else if (read_clear) begin
          status[i] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |((status & ~({N{read_clear}} & ~event_set) | event_set) & mask);
    end
  end
endmodule : brk_event_flags

// ### dv/core_model.sv
// Behavioural core and integration logic answering break requests
`timescale 1ns/1ps
module core_model
  import brk_pkg::*;
#(
  parameter int unsigned RTI_GAP = 40
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic break_request,
  input wire logic slow,
  input wire logic wait_in,
  input wire logic emu_in,
  output core_status_t core
);
  int cnt;
  logic in_brk;
  logic software_interrupt_instruction;
  logic return_from_interrupt_instruction;
  assign core = {software_interrupt_instruction, return_from_interrupt_instruction, wait_in, emu_in};
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cnt <= 0;
      in_brk <= 1'b0;
      software_interrupt_instruction <= 1'b0;
      return_from_interrupt_instruction <= 1'b0;
    end else begin
      software_interrupt_instruction <= 1'b0;
      return_from_interrupt_instruction <= 1'b0;
      if (!in_brk && break_request) begin
        if (cnt >= (slow ? 4 : 0)) begin
          software_interrupt_instruction <= 1'b1;
          in_brk <= 1'b1;
          cnt <= 0;
        end else begin
          cnt <= cnt + 1;
        end
      end else if (in_brk) begin
        cnt <= cnt + 1;
        if (cnt == RTI_GAP) begin
          return_from_interrupt_instruction <= 1'b1;
          in_brk <= 1'b0;
          cnt <= 0;
        end
      end
    end
  end
endmodule : core_model

// ### dv/tb.sv
// Self-checking bench of the address breakpoint unit
`timescale 1ns/1ps
module tb;
  import brk_pkg::*;
  logic core_clk, rst_n, read, write, waitrequest, slow, wait_in, emu_in;
  logic [15:0] address;
  logic [31:0] writedata, readdata, q;
  logic break_request, break_defer_opcode, break_state, flag_clear_allowed, irq;
  cpu_cycle_t cpu;
  core_status_t core;
  logic [7:0] bph, bpl, ev, msk;
  logic cen;
  int failures = 0;
  int total_checks = 0;
  brk_unit u_dut (.core_clk(core_clk), .rst_n(rst_n), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .cpu(cpu), .core(core), .break_request(break_request),
    .break_defer_opcode(break_defer_opcode), .break_state(break_state),
    .flag_clear_allowed(flag_clear_allowed), .irq(irq));
  core_model u_core (.core_clk(core_clk), .rst_n(rst_n), .break_request(break_request),
    .slow(slow), .wait_in(wait_in), .emu_in(emu_in), .core(core));
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  task automatic wrap_up();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : wrap_up
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_reg
  task automatic chk_pin(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_pin
  task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] d);
    int n;
    @(posedge core_clk);
    address <= a;
    read <= !w;
    write <= w;
    writedata <= {24'h00_0000, d};
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    if (waitrequest !== 1'b0) begin
      failures++;
      wrap_up();
    end
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00);
    chk_reg(q, {24'h00_0000, exp});
  endtask : rd
  task automatic hit(input logic [15:0] a, input logic op);
    @(posedge core_clk);
    cpu <= {a, 1'b1, op};
    @(posedge core_clk);
    cpu <= {a, 1'b0, 1'b0};
    @(negedge core_clk);
  endtask : hit
  task automatic wait_for(input logic st, input logic v);
    int n;
    n = 0;
    while ((st ? break_state : break_request) !== v && n < 100) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 100) begin
      failures++;
      wrap_up();
    end
  endtask : wait_for
  initial begin
    repeat (20000) @(posedge core_clk);
    failures++;
    wrap_up();
  end
  initial begin
    logic [15:0] regs [6];
    regs = '{REG_STATUS_CONTROL, REG_BP_HIGH, REG_BP_LOW, REG_WAIT_STATUS, REG_FLAG_CLEAR,
      REG_EVENT_STATUS};
    rst_n = 1'b0;
    {read, write, slow, wait_in, emu_in} = 5'h00;
    address = 16'h0000;
    writedata = 32'h0000_0000;
    cpu = '0;
    ev = 8'h00;
    void'($urandom(32'h1feb));
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 6; i++) rd(regs[i], 8'h00);
    chk_pin(flag_clear_allowed, 1'b1);
    $display("reset test done");
    repeat (3) begin
      bph = 8'($urandom);
      bpl = 8'($urandom);
      bus(1'b1, REG_BP_HIGH, bph);
      bus(1'b1, REG_BP_LOW, bpl);
      rd(REG_BP_HIGH, bph);
      rd(REG_BP_LOW, bpl);
    end
    bus(1'b1, 16'hfe05, 8'hff);
    rd(16'hfe05, 8'h00);
    hit({bph, bpl}, 1'b1);
    chk_pin(break_request, 1'b0);
    rd(REG_STATUS_CONTROL, 8'h00);
    $display("register test done");
    msk = 8'h07;
    bus(1'b1, REG_EVENT_MASK, msk);
    bus(1'b1, REG_STATUS_CONTROL, 8'h80);
    rd(REG_STATUS_CONTROL, 8'h80);
    for (int op = 0; op < 2; op++) begin
      cen = op[0];
      slow <= 1'($urandom);
      bus(1'b1, REG_FLAG_CLEAR, {cen, 7'h00});
      hit({bph, bpl} ^ 16'h0100, op[0]);
      chk_pin(break_request, 1'b0);
      hit({bph, bpl}, op[0]);
      ev = 8'h01;
      chk_pin(break_request, 1'b1);
      chk_pin(break_defer_opcode, op[0]);
      wait_for(1'b1, 1'b1);
      chk_pin(flag_clear_allowed, cen);
      rd(REG_STATUS_CONTROL, 8'hc0);
      chk_pin(irq, 1'b1);
      bus(1'b1, REG_STATUS_CONTROL, 8'h80);
      rd(REG_EVENT_STATUS, ev);
      rd(REG_STATUS_CONTROL, 8'h80);
      chk_pin(irq, 1'b0);
      wait_for(1'b1, 1'b0);
      chk_pin(flag_clear_allowed, 1'b1);
    end
    $display("match test done");
    for (int k = 0; k < 2; k++) begin
      emu_in <= k[0];
      wait_in <= 1'b1;
      msk = k[0] ? 8'h07 : 8'h00;
      bus(1'b1, REG_EVENT_MASK, msk);
      bus(1'b1, REG_STATUS_CONTROL, 8'hc0);
      wait_for(1'b1, 1'b1);
      ev = k[0] ? 8'h06 : 8'h02;
      chk_pin(irq, k[0]);
      rd(REG_WAIT_STATUS, {6'h00, k[0], 1'b0});
      bus(1'b1, REG_WAIT_STATUS, 8'h02);
      rd(REG_WAIT_STATUS, {6'h00, k[0], 1'b0});
      bus(1'b1, REG_WAIT_STATUS, 8'h00);
      rd(REG_WAIT_STATUS, 8'h00);
      bus(1'b1, REG_STATUS_CONTROL, 8'h80);
      rd(REG_EVENT_STATUS, ev);
      wait_for(1'b1, 1'b0);
    end
    $display("forced break test done");
    wrap_up();
  end
endmodule : tb
